// ### spi_pin_pkg.sv
// Constants, field layouts and types shared by the serial port design.
package spi_pin_pkg;

    // ------------------------------------------------------------------
    // Register byte offsets
    // ------------------------------------------------------------------
    localparam logic [7:0] CTRL_OFFSET = 8'h00;
    localparam logic [7:0] DATA_OFFSET = 8'h04;
    localparam logic [7:0] DIV_OFFSET  = 8'h08;

    // ------------------------------------------------------------------
    // Control register field positions
    // ------------------------------------------------------------------
    localparam int unsigned PORT_ENABLE_POS   = 0;
    localparam int unsigned BUSY_POS          = 1;
    localparam int unsigned SELECT_MODE_POS   = 2;
    localparam int unsigned OVERRUN_POS       = 4;
    localparam int unsigned MODE_FAULT_POS    = 5;
    localparam int unsigned WCOL_POS          = 6;
    localparam int unsigned DONE_POS          = 7;
    localparam int unsigned MASTER_ENABLE_POS = 8;

    // ------------------------------------------------------------------
    // Select mode encodings and reset values
    // ------------------------------------------------------------------
    localparam logic [1:0] SEL_3WIRE          = 2'h0;
    localparam logic [1:0] SEL_MULTI          = 2'h1;
    localparam logic [1:0] SELECT_MODE_RESET  = SEL_MULTI;
    localparam logic [7:0] DIV_RESET          = 8'h04;
    localparam logic [7:0] DATA_RESET         = 8'h00;
    localparam logic [2:0] LAST_BIT           = 3'h7;
    localparam int unsigned SYNC_WIDTH        = 4;

    // ------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------
    typedef struct packed {
        logic       master_enable;
        logic [1:0] select_mode;
        logic       port_enable;
    } ctrl_s;

    typedef struct packed {
        logic done;
        logic wcol;
        logic mode_fault;
        logic overrun;
    } flags_s;

    typedef enum logic [1:0] {
        m_idle,
        m_low,
        m_high
    } master_state_e;

endpackage : spi_pin_pkg

// ### sync_two_flop.sv
// Two flip-flop synchroniser for the serial port pin inputs.
`timescale 1ns/1ns
module sync_two_flop
    import spi_pin_pkg::*;
(
    input  wire logic                  clk_i,
    input  wire logic                  rst_i,
    input  wire logic [SYNC_WIDTH-1:0] async_i,
    output logic      [SYNC_WIDTH-1:0] sync_o
);

    logic [SYNC_WIDTH-1:0] stage;

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            stage  <= '0;
            sync_o <= '0;
        end else begin
            stage  <= async_i;
            sync_o <= stage;
        end
    end

endmodule : sync_two_flop

// ### spi_pin_select.sv
// Serial peripheral port with pin direction and select mode logic, APB slave.
//
// Our own choices: the address map and the APB interface to the registers.
`timescale 1ns/1ns

// Summary of operation
// - Full-duplex serial link; the port works as bus master or as slave.
// - Master-to-slave line is output as master, input as slave, MSB first.
// - As master the master-to-slave line carries the shift register top bit.
// - Slave-to-master line is input as master, output as slave, MSB first.
// - Slave-to-master output floats when disabled or when unselected 4-wire slave.
// - A 3-wire slave always drives the shift register top bit out.
// - Master makes and drives the serial clock; a slave only receives it.
// - A 4-wire slave ignores serial clock while its select input is high.
// - Mode 00 is 3-wire, select unused, slave always selected.
// - Mode 01 makes select an input that selects the slave.
// - Mode 01 master: falling select input disables the master function.
// - Mode 1x drives select out at the level of the low mode bit.
// - Select is routed to a pin except in 3-wire mode 00.
// - Master data write fills buffer, starts transfer when shifter empty, sets done flag.
// - Multi-master select falling edge clears master and port enables, sets mode fault.
// - A 4-wire slave clears its bit counter on each select falling edge.
module spi_pin_select
    import spi_pin_pkg::*;
(
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        psel_i,
    input  wire logic        penable_i,
    input  wire logic        pwrite_i,
    input  wire logic [7:0]  paddr_i,
    input  wire logic [31:0] pwdata_i,
    output logic      [31:0] prdata_o,
    output logic             pready_o,
    output logic             pslverr_o,
    input  wire logic        sck_i,
    output logic             sck_o,
    output logic             sck_oe_n_o,
    input  wire logic        mosi_i,
    output logic             mosi_o,
    output logic             mosi_oe_n_o,
    input  wire logic        miso_i,
    output logic             miso_o,
    output logic             miso_oe_n_o,
    input  wire logic        slave_select_i,
    output logic             slave_select_o,
    output logic             slave_select_oe_n_o,
    output logic             select_routed_o
);

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    ctrl_s                 ctrl;
    flags_s                flags;
    master_state_e         m_state;
    logic [7:0]            div;
    logic [7:0]            div_cnt;
    logic [7:0]            tx_buf;
    logic                  tx_full;
    logic [7:0]            rx_buf;
    logic                  rx_full;
    logic [7:0]            shreg;
    logic [2:0]            bit_cnt;
    logic                  rx_bit;
    logic                  slave_loaded;
    logic                  done_evt;
    logic [SYNC_WIDTH-1:0] pins_s;
    logic                  sck_d;
    logic                  ss_d;

    // ------------------------------------------------------------------
    // Pin input synchronisation
    // ------------------------------------------------------------------
    sync_two_flop u_sync (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .async_i ({~slave_select_i, miso_i, mosi_i, sck_i}),
        .sync_o  (pins_s)
    );

    wire sck_s  = pins_s[0];
    wire mosi_s = pins_s[1];
    wire miso_s = pins_s[2];
    wire ss_s   = ~pins_s[3];

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            sck_d <= 1'h0;
            ss_d  <= 1'h1;
        end else begin
            sck_d <= sck_s;
            ss_d  <= ss_s;
        end
    end

    // ------------------------------------------------------------------
    // Decoded conditions
    // ------------------------------------------------------------------
    wire master_mode = ctrl.port_enable & ctrl.master_enable;
    wire slave_mode  = ctrl.port_enable & ~ctrl.master_enable;
    wire sck_rise    = sck_s & ~sck_d;
    wire sck_fall    = ~sck_s & sck_d;
    wire ss_fall     = ~ss_s & ss_d;
    wire mode_3wire  = (ctrl.select_mode == SEL_3WIRE);
    wire mode_multi  = (ctrl.select_mode == SEL_MULTI);
    wire selected    = mode_3wire | (mode_multi & ~ss_s);
    wire fault_evt   = master_mode & mode_multi & ss_fall;
    wire tx_take     = tx_full & ((master_mode & (m_state == m_idle))
                                  | (slave_mode & ~slave_loaded));

    wire apb_acc = psel_i & penable_i & pready_o;
    wire apb_wr  = apb_acc & pwrite_i;
    wire apb_rd  = apb_acc & ~pwrite_i;
    wire wr_ctrl = apb_wr & (paddr_i == CTRL_OFFSET);
    wire wr_data = apb_wr & (paddr_i == DATA_OFFSET);
    wire wr_div  = apb_wr & (paddr_i == DIV_OFFSET);
    wire rd_data = apb_rd & (paddr_i == DATA_OFFSET);
    wire wr_ok   = wr_data & ~(tx_full & ~tx_take);

    function automatic logic addr_mapped(input logic [7:0] a);
        addr_mapped = (a == CTRL_OFFSET) | (a == DATA_OFFSET) | (a == DIV_OFFSET);
    endfunction : addr_mapped

    // ------------------------------------------------------------------
    // APB slave: one wait state, registered answer
    // ------------------------------------------------------------------
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            pready_o  <= 1'h0;
            pslverr_o <= 1'h0;
            prdata_o  <= 32'h0;
        end else begin
            pready_o  <= psel_i & penable_i & ~pready_o;
            pslverr_o <= psel_i & penable_i & ~pready_o & ~addr_mapped(paddr_i);
            prdata_o  <= 32'h0;
            if (psel_i & penable_i & ~pready_o & ~pwrite_i) begin
                case (paddr_i)
                    CTRL_OFFSET: begin
                        prdata_o[MASTER_ENABLE_POS]                 <= ctrl.master_enable;
                        prdata_o[DONE_POS]                          <= flags.done;
                        prdata_o[WCOL_POS]                          <= flags.wcol;
                        prdata_o[MODE_FAULT_POS]                    <= flags.mode_fault;
                        prdata_o[OVERRUN_POS]                       <= flags.overrun;
                        prdata_o[SELECT_MODE_POS+1:SELECT_MODE_POS] <= ctrl.select_mode;
                        prdata_o[BUSY_POS]                          <= (m_state != m_idle);
                        prdata_o[PORT_ENABLE_POS]                   <= ctrl.port_enable;
                    end
                    DATA_OFFSET: prdata_o[7:0] <= rx_buf;
                    DIV_OFFSET:  prdata_o[7:0] <= div;
                    default:     prdata_o      <= 32'h0;
                endcase
            end
        end
    end

    // ------------------------------------------------------------------
    // Control register
    // ------------------------------------------------------------------
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            ctrl.master_enable <= 1'h0;
            ctrl.port_enable   <= 1'h0;
            ctrl.select_mode   <= SELECT_MODE_RESET;
            div                <= DIV_RESET;
        end else begin
            if (wr_ctrl) begin
                ctrl.master_enable <= pwdata_i[MASTER_ENABLE_POS];
                ctrl.port_enable   <= pwdata_i[PORT_ENABLE_POS];
                ctrl.select_mode   <= pwdata_i[SELECT_MODE_POS+1:SELECT_MODE_POS];
            end
            if (fault_evt) begin
                ctrl.master_enable <= 1'h0;
                ctrl.port_enable   <= 1'h0;
            end
            if (wr_div) begin
                div <= pwdata_i[7:0];
            end
        end
    end

    // ------------------------------------------------------------------
    // Status flags: writing zero clears, a new event wins
    // ------------------------------------------------------------------
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            flags <= '0;
        end else begin
            if (wr_ctrl) begin
                flags.done       <= (flags.done & pwdata_i[DONE_POS]) | done_evt;
                flags.wcol       <= (flags.wcol & pwdata_i[WCOL_POS]) | (wr_data & ~wr_ok);
                flags.mode_fault <= (flags.mode_fault & pwdata_i[MODE_FAULT_POS]) | fault_evt;
                flags.overrun    <= (flags.overrun & pwdata_i[OVERRUN_POS])
                                    | (done_evt & slave_mode & rx_full);
            end else begin
                flags.done       <= flags.done | done_evt;
                flags.wcol       <= flags.wcol | (wr_data & ~wr_ok);
                flags.mode_fault <= flags.mode_fault | fault_evt;
                flags.overrun    <= flags.overrun | (done_evt & slave_mode & rx_full);
            end
        end
    end

    // ------------------------------------------------------------------
    // Transmit and receive buffers
    // ------------------------------------------------------------------
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            tx_buf  <= DATA_RESET;
            tx_full <= 1'h0;
        end else if (wr_ok) begin
            tx_buf  <= pwdata_i[7:0];
            tx_full <= 1'h1;
        end else if (tx_take) begin
            tx_full <= 1'h0;
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            rx_buf  <= DATA_RESET;
            rx_full <= 1'h0;
        end else if (done_evt & ~(slave_mode & rx_full)) begin
            rx_buf  <= shreg;
            rx_full <= 1'h1;
        end else if (rd_data) begin
            rx_full <= 1'h0;
        end
    end

    // ------------------------------------------------------------------
    // Shift engine for master and slave
    // ------------------------------------------------------------------
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            m_state      <= m_idle;
            div_cnt      <= 8'h00;
            shreg        <= DATA_RESET;
            bit_cnt      <= 3'h0;
            rx_bit       <= 1'h0;
            slave_loaded <= 1'h0;
            done_evt     <= 1'h0;
        end else begin
            done_evt <= 1'h0;
            if (master_mode) begin
                slave_loaded <= 1'h0;
                case (m_state)
                    m_idle: begin
                        if (tx_take) begin
                            shreg   <= tx_buf;
                            bit_cnt <= 3'h0;
                            div_cnt <= 8'h00;
                            m_state <= m_low;
                        end
                    end
                    m_low: begin
                        if (div_cnt == div) begin
                            div_cnt <= 8'h00;
                            rx_bit  <= miso_s;
                            m_state <= m_high;
                        end else begin
                            div_cnt <= div_cnt + 8'h01;
                        end
                    end
                    m_high: begin
                        if (div_cnt == div) begin
                            div_cnt <= 8'h00;
                            shreg   <= {shreg[6:0], rx_bit};
                            if (bit_cnt == LAST_BIT) begin
                                done_evt <= 1'h1;
                                m_state  <= m_idle;
                            end else begin
                                bit_cnt <= bit_cnt + 3'h1;
                                m_state <= m_low;
                            end
                        end else begin
                            div_cnt <= div_cnt + 8'h01;
                        end
                    end
                    default: m_state <= m_idle;
                endcase
            end else begin
                m_state <= m_idle;
                div_cnt <= 8'h00;
                if (!slave_mode) begin
                    bit_cnt      <= 3'h0;
                    slave_loaded <= 1'h0;
                end else if (mode_multi & ss_fall) begin
                    bit_cnt <= 3'h0;
                end else if (tx_take) begin
                    shreg        <= tx_buf;
                    slave_loaded <= 1'h1;
                end else if (selected & sck_rise) begin
                    rx_bit <= mosi_s;
                end else if (selected & sck_fall) begin
                    shreg <= {shreg[6:0], rx_bit};
                    if (bit_cnt == LAST_BIT) begin
                        done_evt     <= 1'h1;
                        slave_loaded <= 1'h0;
                        bit_cnt      <= 3'h0;
                    end else begin
                        bit_cnt <= bit_cnt + 3'h1;
                    end
                end
            end
        end
    end

    // ------------------------------------------------------------------
    // Pin drivers
    // ------------------------------------------------------------------
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            sck_o               <= 1'h0;
            sck_oe_n_o          <= 1'h1;
            mosi_o              <= 1'h0;
            mosi_oe_n_o         <= 1'h1;
            miso_o              <= 1'h0;
            miso_oe_n_o         <= 1'h1;
            slave_select_o      <= 1'h1;
            slave_select_oe_n_o <= 1'h1;
            select_routed_o     <= 1'h1;
        end else begin
            sck_o               <= (m_state == m_high);
            sck_oe_n_o          <= ~master_mode;
            mosi_o              <= shreg[7];
            mosi_oe_n_o         <= ~master_mode;
            miso_o              <= shreg[7];
            miso_oe_n_o         <= ~(slave_mode & selected);
            slave_select_o      <= ctrl.select_mode[0];
            slave_select_oe_n_o <= ~ctrl.select_mode[1];
            select_routed_o     <= ~mode_3wire;
        end
    end

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    chk_miso_float_off: assert property (!ctrl.port_enable |=> miso_oe_n_o)
        else $error("miso driven while port disabled");
    chk_miso_unselected: assert property (slave_mode && mode_multi && ss_s |=> miso_oe_n_o)
        else $error("miso driven by unselected slave");
    chk_mosi_master: assert property (master_mode |=> !mosi_oe_n_o && !sck_oe_n_o)
        else $error("master not driving mosi and sck");
    chk_mosi_msb: assert property (m_state == m_high |=> mosi_o == $past(shreg[7]))
        else $error("mosi not from shift register top bit");
    chk_slave_3wire: assert property (slave_mode && mode_3wire |=> !miso_oe_n_o && mosi_oe_n_o)
        else $error("3-wire slave pin directions wrong");
    chk_fault_clear: assert property (fault_evt |=> !ctrl.master_enable && !ctrl.port_enable
                                      && flags.mode_fault ##1 mosi_oe_n_o)
        else $error("mode fault did not disable master");
    chk_sck_ignored: assert property (slave_mode && mode_multi && ss_s && ss_d
                                      |=> $stable(bit_cnt) && !done_evt)
        else $error("unselected slave counted clock");
    chk_bitcnt_clear: assert property (slave_mode && mode_multi && ss_fall |=> bit_cnt == 3'h0)
        else $error("bit counter not cleared on select fall");
    chk_select_out: assert property (ctrl.select_mode[1] |=> !slave_select_oe_n_o
                                     && slave_select_o == $past(ctrl.select_mode[0]))
        else $error("select output level wrong");
    chk_select_route: assert property (mode_3wire |=> !select_routed_o)
        else $error("select routed in 3-wire mode");
    chk_master_start: assert property (master_mode && tx_take |=> m_state == m_low && !tx_full
                                       ##[1:600] (m_state == m_high || !master_mode))
        else $error("master transfer did not start");

endmodule : spi_pin_select

// ### spi_far_model.sv
// Behavioural far-side serial device, acting as slave or as master.
`timescale 1ns/1ns
module spi_far_model (
    input  wire logic       sck_i,
    input  wire logic       mosi_i,
    input  wire logic       miso_i,
    input  wire logic       sel_n_i,
    input  wire logic [7:0] tx_byte_i,
    output logic            sck_o,
    output logic            mosi_o,
    output logic            miso_o,
    output logic            sel_n_o,
    output logic [7:0]      rx_byte_o
);
    logic [7:0] shift;
    logic       is_master;
    initial begin
        sck_o = 1'h0;
        sel_n_o = 1'h1;
        is_master = 1'h0;
        shift = 8'h00;
        rx_byte_o = 8'h00;
    end
    // ------------------------------------------------------------------
    // Line drive; a released line shows the inverse bit, not a held value.
    // ------------------------------------------------------------------
    assign mosi_o = is_master ? shift[7] : ~shift[7];
    assign miso_o = (!is_master && !sel_n_i) ? shift[7] : ~shift[7];
    always @(negedge sel_n_i) if (!is_master) shift = tx_byte_i;
    always @(posedge sck_i) rx_byte_o <= {rx_byte_o[6:0], is_master ? miso_i : mosi_i};
    always @(negedge sck_i) shift <= {shift[6:0], 1'h0};
    task automatic send(input logic [7:0] b, input logic sel_lvl);
        is_master = 1'h1;
        shift = b;
        sel_n_o = sel_lvl;
        #100;
        repeat (8) begin
            #40 sck_o = 1'h1;
            #40 sck_o = 1'h0;
        end
        #100 sel_n_o = 1'h1;
        is_master = 1'h0;
    endtask : send
endmodule : spi_far_model

// ### testbench.sv
// Self-checking bench for the serial port pin and select mode logic.
`timescale 1ns/1ns
module testbench import spi_pin_pkg::*;;
    logic        clk_i = 1'h0, rst_i = 1'h1, psel_i = 1'h0, penable_i = 1'h0, pwrite_i = 1'h0;
    logic [7:0]  paddr_i = 8'h00, tx = 8'h00, f_rx;
    logic [31:0] pwdata_i = 32'h0, prdata_o, rd;
    logic        pready_o, pslverr_o, err, sck_o, sck_oe_n_o, mosi_o, mosi_oe_n_o, miso_o;
    logic        miso_oe_n_o, sel_n_out, sel_n_oe_n, routed, f_sck, f_mosi, f_miso, f_sel_n;
    wire         sck = sck_oe_n_o ? f_sck : sck_o;
    wire         mosi = mosi_oe_n_o ? f_mosi : mosi_o;
    wire         miso = miso_oe_n_o ? f_miso : miso_o;
    wire         sel_n = sel_n_oe_n ? f_sel_n : sel_n_out;
    int          failures = 0, tests_run = 0, cycles = 0;
    spi_pin_select dut (.clk_i(clk_i), .rst_i(rst_i), .psel_i(psel_i), .penable_i(penable_i),
        .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
        .pready_o(pready_o), .pslverr_o(pslverr_o), .sck_i(sck), .sck_o(sck_o),
        .sck_oe_n_o(sck_oe_n_o), .mosi_i(mosi), .mosi_o(mosi_o), .mosi_oe_n_o(mosi_oe_n_o),
        .miso_i(miso), .miso_o(miso_o), .miso_oe_n_o(miso_oe_n_o), .slave_select_i(sel_n),
        .slave_select_o(sel_n_out), .slave_select_oe_n_o(sel_n_oe_n), .select_routed_o(routed));
    spi_far_model far (.sck_i(sck), .mosi_i(mosi), .miso_i(miso), .sel_n_i(sel_n),
        .tx_byte_i(tx), .sck_o(f_sck), .mosi_o(f_mosi), .miso_o(f_miso), .sel_n_o(f_sel_n),
        .rx_byte_o(f_rx));
    // ------------------------------------------------------------------
    // Clock, timeout and shared tasks.
    // ------------------------------------------------------------------
    always #5 clk_i = ~clk_i;
    always @(posedge clk_i) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            failures = failures + 1;
            tally_and_finish();
        end
    end
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
            failures++;
        end
    endtask : check
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_i);
        psel_i <= 1'h1;
        pwrite_i <= w;
        paddr_i <= a;
        pwdata_i <= d;
        @(posedge clk_i);
        penable_i <= 1'h1;
        @(posedge clk_i);
        while (pready_o !== 1'h1) @(posedge clk_i);
        rd = prdata_o;
        err = pslverr_o;
        psel_i <= 1'h0;
        penable_i <= 1'h0;
    endtask : apb
    task automatic settle;
        repeat (3) @(posedge clk_i);
        #1;
    endtask : settle
    task automatic t_reset;
        settle;
        check("pin enables", 32'h7, 32'({sck_oe_n_o, mosi_oe_n_o, miso_oe_n_o}));
        apb(1'h0, CTRL_OFFSET, 32'h0);
        check("ctrl reset", 32'h4, rd);
        apb(1'h0, 8'h0C, 32'h0);
        check("unmapped err", 32'h1, 32'(err));
    endtask : t_reset
    task automatic t_master;
        int n;
        n = 0;
        tx = 8'h3C;
        apb(1'h1, DIV_OFFSET, 32'(DIV_RESET));
        apb(1'h1, CTRL_OFFSET, 32'h109);
        settle;
        check("select out low", 32'h0, 32'({sel_n_out, sel_n_oe_n}));
        check("routed", 32'h1, 32'(routed));
        apb(1'h1, DATA_OFFSET, 32'hA5);
        do begin
            apb(1'h0, CTRL_OFFSET, 32'h0);
            n++;
        end while (rd[7] !== 1'h1 && n < 200);
        check("mosi byte", 32'hA5, 32'(f_rx));
        apb(1'h0, DATA_OFFSET, 32'h0);
        check("miso byte", 32'h3C, rd);
        check("sck idle", 32'h0, 32'(sck));
        apb(1'h1, CTRL_OFFSET, 32'h10D);
        settle;
        check("select out high", 32'h1, 32'(sel_n_out));
    endtask : t_master
    task automatic t_fault;
        apb(1'h1, CTRL_OFFSET, 32'h101);
        settle;
        check("routed 3-wire", 32'h0, 32'(routed));
        apb(1'h1, CTRL_OFFSET, 32'h105);
        settle;
        check("master drives", 32'h0, 32'({sck_oe_n_o, mosi_oe_n_o}));
        far.sel_n_o = 1'h0;
        settle;
        apb(1'h0, CTRL_OFFSET, 32'h0);
        check("fault ctrl", 32'h24, rd);
        check("pins float", 32'h3, 32'({sck_oe_n_o, mosi_oe_n_o}));
        far.sel_n_o = 1'h1;
    endtask : t_fault
    task automatic t_slave;
        apb(1'h1, CTRL_OFFSET, 32'h5);
        apb(1'h1, DATA_OFFSET, 32'h96);
        settle;
        check("unselected miso", 32'h1, 32'(miso_oe_n_o));
        far.send(8'hFF, 1'h1);
        apb(1'h0, CTRL_OFFSET, 32'h0);
        check("ignored sck", 32'h0, 32'(rd[7]));
        far.sel_n_o = 1'h0;
        settle;
        check("selected miso", 32'h0, 32'(miso_oe_n_o));
        far.send(8'h5A, 1'h0);
        check("slave miso byte", 32'h96, 32'(f_rx));
        apb(1'h0, DATA_OFFSET, 32'h0);
        check("slave byte", 32'h5A, rd);
        apb(1'h1, CTRL_OFFSET, 32'h1);
        settle;
        check("3-wire miso", 32'h0, 32'(miso_oe_n_o));
        apb(1'h1, CTRL_OFFSET, 32'h0);
        settle;
        check("disabled miso", 32'h1, 32'(miso_oe_n_o));
    endtask : t_slave
    task automatic tally_and_finish;
        $display("Checks run %0d, failures %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : tally_and_finish
    initial begin
        repeat (2) @(posedge clk_i);
        rst_i <= 1'h0;
        t_reset;
        t_master;
        t_fault;
        t_slave;
        tally_and_finish;
    end
endmodule : testbench
